/* File: rtl/sud_pkg.sv */
// Purpose: shared constants and types for the store decode and execute block
// Assumes: instruction word holds the first halfword in [31:16]
// Notes: register offsets are byte addresses on the AHB-Lite slave
package sud_pkg;
	// register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_INSN = 8'h04;
	localparam logic [7:0] REG_BASE = 8'h08;
	localparam logic [7:0] REG_SRC = 8'h0C;
	localparam logic [7:0] REG_SRC2 = 8'h10;
	localparam logic [7:0] REG_STAT = 8'h14;
	localparam logic [7:0] REG_WBADDR = 8'h18;
	localparam logic [7:0] REG_RESULT = 8'h1C;
	localparam logic [26:0] MAP_HIGH = 27'h0;
	// control and status bit positions
	localparam int CTRL_START = 0;
	localparam int CTRL_COND = 1;
	localparam int STB_BUSY = 0;
	localparam int STB_DONE = 1;
	localparam int STB_UNDEF = 2;
	localparam int STB_UNPRED = 3;
	localparam int STB_PROT = 4;
	localparam int STB_BUSERR = 5;
	localparam int STB_EXFAIL = 6;
	localparam int STB_WBVALID = 7;
	localparam int STB_RELATED = 8;
	localparam int STB_NOMATCH = 9;
	// reset values
	localparam logic [31:0] RST_WORD = 32'h0;
	localparam logic RST_COND = 1'b1;
	// encoding marks
	localparam logic [11:0] ENC_BYTE_USER = 12'hF80;
	localparam logic [3:0] ENC_BYTE_USER_HW2 = 4'hE;
	localparam logic [6:0] ENC_PAIR = 7'h74;
	localparam logic [11:0] ENC_WORD_EXCL = 12'hE84;
	localparam logic [11:0] ENC_SUB_EXCL = 12'hE8C;
	localparam logic [7:0] ENC_BYTE_EXCL = 8'hF4;
	localparam logic [7:0] ENC_HALF_EXCL = 8'hF5;
	localparam logic [3:0] REG_NUM_SP = 4'hD;
	localparam logic [3:0] REG_NUM_PC = 4'hF;
	localparam logic [31:0] PAIR_STEP = 32'h4;
	// access sizes
	typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_HALF = 2'h1, SZ_WORD = 2'h2} sud_size_t;
	// decoded operation, one-hot
	typedef enum logic [5:0] {
		OP_NONE = 6'h01,
		OP_BYTE_USER = 6'h02,
		OP_PAIR = 6'h04,
		OP_WORD_EXCL = 6'h08,
		OP_BYTE_EXCL = 6'h10,
		OP_HALF_EXCL = 6'h20
	} sud_op_t;
	// execution states, one-hot
	typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_FIRST = 3'h2, ST_SECOND = 3'h4} sud_state_t;
endpackage

/* File: rtl/sud_decode.sv */
// Purpose: field decode and legality checks for the store group
// Assumes: insn is stable while an operation runs
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module sud_decode (
	// instruction in
	input wire logic [31:0] insn,
	// decoded fields
	output sud_pkg::sud_op_t op,
	output logic [3:0] base_idx,
	output logic [3:0] src_idx,
	output logic [3:0] src2_idx,
	output logic [3:0] stat_idx,
	output logic [31:0] imm32,
	output logic pre_index,
	output logic add_off,
	output logic wback,
	// legality
	output logic undef,
	output logic unpred,
	output logic related
);
	logic m_bu, m_pr, m_we, m_be, m_he, reg_bad_t, reg_bad_t2;
	// encoding matches
	assign m_bu = insn[31:20] == sud_pkg::ENC_BYTE_USER && insn[11:8] == sud_pkg::ENC_BYTE_USER_HW2;
	assign m_pr = insn[31:25] == sud_pkg::ENC_PAIR && insn[22] && !insn[20] && !m_we && !m_be && !m_he;
	assign m_we = insn[31:20] == sud_pkg::ENC_WORD_EXCL;
	assign m_be = insn[31:20] == sud_pkg::ENC_SUB_EXCL && insn[11:4] == sud_pkg::ENC_BYTE_EXCL;
	assign m_he = insn[31:20] == sud_pkg::ENC_SUB_EXCL && insn[11:4] == sud_pkg::ENC_HALF_EXCL;
	// register fields
	assign base_idx = insn[19:16];
	assign src_idx = insn[15:12];
	assign src2_idx = insn[11:8];
	assign stat_idx = m_we ? insn[11:8] : insn[3:0];
	assign reg_bad_t = src_idx == sud_pkg::REG_NUM_SP || src_idx == sud_pkg::REG_NUM_PC;
	assign reg_bad_t2 = src2_idx == sud_pkg::REG_NUM_SP || src2_idx == sud_pkg::REG_NUM_PC;
	// operation select
	always_comb begin
		op = sud_pkg::OP_NONE;
		if (m_bu) begin
			op = sud_pkg::OP_BYTE_USER;
		end else if (m_pr) begin
			op = sud_pkg::OP_PAIR;
		end else if (m_we) begin
			op = sud_pkg::OP_WORD_EXCL;
		end else if (m_be) begin
			op = sud_pkg::OP_BYTE_EXCL;
		end else if (m_he) begin
			op = sud_pkg::OP_HALF_EXCL;
		end
	end
	// offset: plain byte, scaled by four, or none
	assign imm32 = m_bu ? {24'h0, insn[7:0]} : ((m_pr || m_we) ? {22'h0, insn[7:0], 2'h0} : 32'h0);
	// addressing controls, fixed pre-index add for everything but the pair
	assign pre_index = m_pr ? insn[24] : 1'b1;
	assign add_off = m_pr ? insn[23] : 1'b1;
	assign wback = m_pr && insn[21];
	assign related = m_pr && !insn[24] && !insn[21];
	assign undef = m_bu && base_idx == sud_pkg::REG_NUM_PC;
	// unpredictable register choices
	always_comb begin
		unpred = 1'b0;
		if (m_bu) begin
			unpred = reg_bad_t;
		end else if (m_pr) begin
			unpred = (wback && (base_idx == src_idx || base_idx == src2_idx))
				|| base_idx == sud_pkg::REG_NUM_PC || reg_bad_t || reg_bad_t2;
		end else if (m_we || m_be || m_he) begin
			unpred = stat_idx == sud_pkg::REG_NUM_SP || stat_idx == sud_pkg::REG_NUM_PC
				|| reg_bad_t || base_idx == sud_pkg::REG_NUM_PC
				|| stat_idx == base_idx || stat_idx == src_idx;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/sud_agen.sv */
// Purpose: address forming for the store group
// Assumes: add and index are fixed to one for non-pair forms
// Notes: arithmetic wraps at 32 bits
`timescale 1ns/1ps
`default_nettype none
module sud_agen (
	// operands
	input wire logic [31:0] base,
	input wire logic [31:0] imm32,
	input wire logic add_off,
	input wire logic pre_index,
	// addresses
	output logic [31:0] offset_addr,
	output logic [31:0] first_addr
);
	// base plus or minus offset, then pre or post select
	assign offset_addr = add_off ? base + imm32 : base - imm32;
	assign first_addr = pre_index ? offset_addr : base;
endmodule
`default_nettype wire

/* File: rtl/sud_core.sv */
// Purpose: execute unit for byte-user, word-pair and exclusive stores
// Assumes: single-word AHB-Lite transfers; memory acks a held request
// Notes: flagged encodings never reach memory
`timescale 1ns/1ps
`default_nettype none
module sud_core (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// memory system
	output logic mem_req,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	output logic [1:0] mem_size,
	output logic mem_unpriv,
	output logic mem_excl,
	output logic mem_aligned,
	input wire logic mem_ack,
	input wire logic mem_excl_pass,
	input wire logic mem_prot_fault,
	input wire logic mem_bus_fault,
	// exception pulses
	output logic protection_fault,
	output logic bus_error_fault,
	output logic undef_exc
);
	logic pend_q, a_wr_q, a_hit_q, hreadyout_q, hresp_q, wr_en, rd_en, busy;
	logic [7:0] a_addr_q;
	logic [31:0] hrdata_q, insn_q, base_q, src_q, src2_q, wb_addr_q, result_q, stat_word;
	logic start_q, cond_q, blocked, go, ack_ok, ack_flt;
	logic done_q, undef_q, unpred_q, prot_q, buserr_q, exfail_q, wbv_q, related_q, nomatch_q;
	logic mem_req_q, mem_unpriv_q, mem_excl_q, mem_aligned_q, prot_exc_q, bus_exc_q, undef_exc_q;
	logic [31:0] mem_addr_q, mem_wdata_q, wdata1, offset_addr, first_addr, imm32;
	sud_pkg::sud_size_t mem_size_q, size1;
	sud_pkg::sud_state_t state_q;
	sud_pkg::sud_op_t op;
	logic [3:0] base_idx, src_idx, src2_idx, stat_idx;
	logic pre_index, add_off, wback, dec_undef, dec_unpred, dec_related, is_excl;

	// field decode of the held instruction
	sud_decode u_dec (
		.insn(insn_q),
		.op(op),
		.base_idx(base_idx),
		.src_idx(src_idx),
		.src2_idx(src2_idx),
		.stat_idx(stat_idx),
		.imm32(imm32),
		.pre_index(pre_index),
		.add_off(add_off),
		.wback(wback),
		.undef(dec_undef),
		.unpred(dec_unpred),
		.related(dec_related)
	);

	// address forming
	sud_agen u_agen (
		.base(base_q),
		.imm32(imm32),
		.add_off(add_off),
		.pre_index(pre_index),
		.offset_addr(offset_addr),
		.first_addr(first_addr)
	);

	// bus phase tracking: every transfer gets one wait state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_q <= 1'b0;
			hreadyout_q <= 1'b1;
			a_wr_q <= 1'b0;
			a_hit_q <= 1'b0;
			a_addr_q <= 8'h0;
		end else if (pend_q) begin
			pend_q <= 1'b0;
			hreadyout_q <= 1'b1;
		end else if (hsel && htrans[1] && hready) begin
			pend_q <= 1'b1;
			hreadyout_q <= 1'b0;
			a_wr_q <= hwrite;
			a_hit_q <= haddr[31:5] == sud_pkg::MAP_HIGH;
			a_addr_q <= haddr[7:0];
		end
	end

	assign wr_en = pend_q && a_wr_q && a_hit_q;
	assign rd_en = pend_q && !a_wr_q;
	assign busy = start_q || state_q != sud_pkg::ST_IDLE;

	// status word assembled from the live busy bit and sticky flags
	always_comb begin
		stat_word = sud_pkg::RST_WORD;
		stat_word[sud_pkg::STB_BUSY] = busy;
		stat_word[sud_pkg::STB_DONE] = done_q;
		stat_word[sud_pkg::STB_UNDEF] = undef_q;
		stat_word[sud_pkg::STB_UNPRED] = unpred_q;
		stat_word[sud_pkg::STB_PROT] = prot_q;
		stat_word[sud_pkg::STB_BUSERR] = buserr_q;
		stat_word[sud_pkg::STB_EXFAIL] = exfail_q;
		stat_word[sud_pkg::STB_WBVALID] = wbv_q;
		stat_word[sud_pkg::STB_RELATED] = related_q;
		stat_word[sud_pkg::STB_NOMATCH] = nomatch_q;
	end

	// read data, unmapped reads return zero; response is always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= sud_pkg::RST_WORD;
			hresp_q <= 1'b0;
		end else if (rd_en) begin
			hrdata_q <= sud_pkg::RST_WORD;
			if (a_hit_q) begin
				case (a_addr_q)
					sud_pkg::REG_CTRL: hrdata_q <= {30'h0, cond_q, 1'b0};
					sud_pkg::REG_INSN: hrdata_q <= insn_q;
					sud_pkg::REG_BASE: hrdata_q <= base_q;
					sud_pkg::REG_SRC: hrdata_q <= src_q;
					sud_pkg::REG_SRC2: hrdata_q <= src2_q;
					sud_pkg::REG_STAT: hrdata_q <= stat_word;
					sud_pkg::REG_WBADDR: hrdata_q <= wb_addr_q;
					sud_pkg::REG_RESULT: hrdata_q <= result_q;
					default: hrdata_q <= sud_pkg::RST_WORD;
				endcase
			end
		end
	end

	// operand registers, writes ignored while an operation runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			insn_q <= sud_pkg::RST_WORD;
			base_q <= sud_pkg::RST_WORD;
			src_q <= sud_pkg::RST_WORD;
			src2_q <= sud_pkg::RST_WORD;
			cond_q <= sud_pkg::RST_COND;
			start_q <= 1'b0;
		end else begin
			start_q <= 1'b0;
			if (wr_en && !busy) begin
				case (a_addr_q)
					sud_pkg::REG_CTRL: begin
						cond_q <= hwdata[sud_pkg::CTRL_COND];
						start_q <= hwdata[sud_pkg::CTRL_START];
					end
					sud_pkg::REG_INSN: insn_q <= hwdata;
					sud_pkg::REG_BASE: base_q <= hwdata;
					sud_pkg::REG_SRC: src_q <= hwdata;
					sud_pkg::REG_SRC2: src2_q <= hwdata;
					default: ;
				endcase
			end
		end
	end

	// first access shape
	assign is_excl = op == sud_pkg::OP_WORD_EXCL || op == sud_pkg::OP_BYTE_EXCL || op == sud_pkg::OP_HALF_EXCL;
	assign blocked = dec_undef || dec_unpred || dec_related || op == sud_pkg::OP_NONE;
	assign go = start_q && cond_q && !blocked;
	assign ack_ok = mem_req_q && mem_ack && !mem_prot_fault && !mem_bus_fault;
	assign ack_flt = mem_req_q && mem_ack && (mem_prot_fault || mem_bus_fault);
	always_comb begin
		wdata1 = src_q;
		size1 = sud_pkg::SZ_WORD;
		if (op == sud_pkg::OP_BYTE_USER || op == sud_pkg::OP_BYTE_EXCL) begin
			wdata1 = {24'h0, src_q[7:0]};
			size1 = sud_pkg::SZ_BYTE;
		end else if (op == sud_pkg::OP_HALF_EXCL) begin
			wdata1 = {16'h0, src_q[15:0]};
			size1 = sud_pkg::SZ_HALF;
		end
	end

	// memory request sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= sud_pkg::ST_IDLE;
			mem_req_q <= 1'b0;
			mem_addr_q <= sud_pkg::RST_WORD;
			mem_wdata_q <= sud_pkg::RST_WORD;
			mem_size_q <= sud_pkg::SZ_WORD;
			mem_unpriv_q <= 1'b0;
			mem_excl_q <= 1'b0;
			mem_aligned_q <= 1'b0;
		end else begin
			case (state_q)
				sud_pkg::ST_IDLE: begin
					if (go) begin
						mem_req_q <= 1'b1;
						mem_addr_q <= first_addr;
						mem_wdata_q <= wdata1;
						mem_size_q <= size1;
						mem_unpriv_q <= op == sud_pkg::OP_BYTE_USER;
						mem_excl_q <= is_excl;
						mem_aligned_q <= op != sud_pkg::OP_BYTE_USER;
						state_q <= sud_pkg::ST_FIRST;
					end
				end
				sud_pkg::ST_FIRST: begin
					if (mem_ack) begin
						if (ack_ok && op == sud_pkg::OP_PAIR) begin
							mem_addr_q <= mem_addr_q + sud_pkg::PAIR_STEP;
							mem_wdata_q <= src2_q;
							state_q <= sud_pkg::ST_SECOND;
						end else begin
							mem_req_q <= 1'b0;
							state_q <= sud_pkg::ST_IDLE;
						end
					end
				end
				sud_pkg::ST_SECOND: begin
					if (mem_ack) begin
						mem_req_q <= 1'b0;
						state_q <= sud_pkg::ST_IDLE;
					end
				end
				default: begin
					mem_req_q <= 1'b0;
					state_q <= sud_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// sticky outcome flags, cleared by the next start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			{done_q, undef_q, unpred_q, prot_q, buserr_q} <= 5'h0;
			{exfail_q, wbv_q, related_q, nomatch_q} <= 4'h0;
			result_q <= sud_pkg::RST_WORD;
			wb_addr_q <= sud_pkg::RST_WORD;
		end else if (start_q) begin
			{done_q, undef_q, unpred_q, prot_q, buserr_q} <= 5'h0;
			{exfail_q, wbv_q, related_q, nomatch_q} <= 4'h0;
			done_q <= !go;
			if (cond_q) begin
				undef_q <= dec_undef;
				unpred_q <= dec_unpred;
				related_q <= dec_related;
				nomatch_q <= op == sud_pkg::OP_NONE;
			end
		end else if (ack_flt) begin
			prot_q <= mem_prot_fault;
			buserr_q <= mem_bus_fault;
			done_q <= 1'b1;
		end else if (ack_ok) begin
			if (state_q == sud_pkg::ST_FIRST && mem_excl_q) begin
				exfail_q <= !mem_excl_pass;
				result_q <= {31'h0, !mem_excl_pass};
				done_q <= 1'b1;
			end else if (state_q == sud_pkg::ST_SECOND) begin
				done_q <= 1'b1;
				if (wback) begin
					wb_addr_q <= offset_addr;
					wbv_q <= 1'b1;
				end
			end else if (op != sud_pkg::OP_PAIR) begin
				done_q <= 1'b1;
			end
		end
	end

	// exception pulses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prot_exc_q <= 1'b0;
			bus_exc_q <= 1'b0;
			undef_exc_q <= 1'b0;
		end else begin
			prot_exc_q <= ack_flt && mem_prot_fault;
			bus_exc_q <= ack_flt && mem_bus_fault;
			undef_exc_q <= start_q && cond_q && dec_undef;
		end
	end

	assign hreadyout = hreadyout_q;
	assign hresp = hresp_q;
	assign hrdata = hrdata_q;
	assign mem_req = mem_req_q;
	assign mem_addr = mem_addr_q;
	assign mem_wdata = mem_wdata_q;
	assign mem_size = mem_size_q;
	assign mem_unpriv = mem_unpriv_q;
	assign mem_excl = mem_excl_q;
	assign mem_aligned = mem_aligned_q;
	assign protection_fault = prot_exc_q;
	assign bus_error_fault = bus_exc_q;
	assign undef_exc = undef_exc_q;

	// checks
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_byte_user_shape: assert property (mem_req_q && op == sud_pkg::OP_BYTE_USER |-> mem_unpriv_q
		&& mem_size_q == sud_pkg::SZ_BYTE && mem_wdata_q[31:8] == 24'h0 && mem_addr_q == base_q + {24'h0, insn_q[7:0]})
		else $error("byte-user access shape wrong");
	a_undef_base: assert property (start_q && cond_q && op == sud_pkg::OP_BYTE_USER && insn_q[19:16] == 4'hF
		|=> undef_q && undef_exc_q && !mem_req_q) else $error("undefined base not flagged");
	a_unpred_src: assert property (start_q && cond_q && op == sud_pkg::OP_BYTE_USER && insn_q[15:12] == 4'hD
		|=> unpred_q && !mem_req_q) else $error("stack pointer source not flagged");
	a_pair_second: assert property (state_q == sud_pkg::ST_FIRST && ack_ok && op == sud_pkg::OP_PAIR
		|=> mem_req_q && mem_addr_q == $past(mem_addr_q) + 32'h4 && mem_wdata_q == src2_q)
		else $error("second word address wrong");
	a_pair_wback: assert property (state_q == sud_pkg::ST_SECOND && ack_ok && wback
		|=> wbv_q && wb_addr_q == (insn_q[23] ? base_q + {22'h0, insn_q[7:0], 2'h0}
		: base_q - {22'h0, insn_q[7:0], 2'h0})) else $error("writeback wrong");
	a_no_wback: assert property ($rose(wbv_q) |-> $past(state_q) == sud_pkg::ST_SECOND && op == sud_pkg::OP_PAIR)
		else $error("writeback outside pair");
	a_related_skip: assert property (start_q && op == sud_pkg::OP_PAIR && !insn_q[24] && !insn_q[21]
		|=> !mem_req_q [*2]) else $error("related encoding executed");
	a_word_excl: assert property (mem_req_q && mem_excl_q && mem_size_q == sud_pkg::SZ_WORD
		|-> mem_addr_q == base_q + {22'h0, insn_q[7:0], 2'h0}) else $error("exclusive word address wrong");
	a_sub_excl: assert property (mem_req_q && mem_excl_q && mem_size_q != sud_pkg::SZ_WORD
		|-> mem_addr_q == base_q && mem_aligned_q) else $error("exclusive byte or half address wrong");
	a_excl_status: assert property (state_q == sud_pkg::ST_FIRST && ack_ok && mem_excl_q
		|=> result_q == {31'h0, !$past(mem_excl_pass)} && done_q) else $error("exclusive status wrong");
	a_fault_raise: assert property (ack_flt |=> (protection_fault == $past(mem_prot_fault))
		&& (bus_error_fault == $past(mem_bus_fault)) && !mem_req_q) else $error("fault not raised");
	a_cond_quiet: assert property (start_q && !cond_q |=> !mem_req_q && done_q && !wbv_q ##1 !mem_req_q)
		else $error("failed condition still acted");
endmodule
`default_nettype wire

/* File: sim/sud_mem_model.sv */
// Purpose: memory system partner that answers store requests with ack, exclusive result and faults
// Assumes: one request at a time, held by the store unit until acked
// Notes: flags carry meaning only in the ack cycle and show the inverse otherwise
`timescale 1ns/1ps
`default_nettype none
module sud_mem_model (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// request from the store unit
	input wire logic mem_req,
	// behaviour chosen by the bench
	input wire logic [3:0] delay,
	input wire logic pass_cfg,
	input wire logic prot_cfg,
	input wire logic bus_cfg,
	// answer
	output logic mem_ack,
	output logic mem_excl_pass,
	output logic mem_prot_fault,
	output logic mem_bus_fault
);
	logic [3:0] wait_q;
	// count wait cycles, then one ack pulse per held request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_q <= 4'h0;
			mem_ack <= 1'b0;
		end else if (mem_req && !mem_ack && wait_q == delay) begin
			wait_q <= 4'h0;
			mem_ack <= 1'b1;
		end else begin
			wait_q <= (mem_req && !mem_ack) ? wait_q + 4'h1 : 4'h0;
			mem_ack <= 1'b0;
		end
	end
	// exclusive check result and fault reports travel with the ack
	assign mem_excl_pass = mem_ack ? pass_cfg : ~pass_cfg;
	assign mem_prot_fault = mem_ack ? prot_cfg : ~prot_cfg;
	assign mem_bus_fault = mem_ack ? bus_cfg : ~bus_cfg;
endmodule
`default_nettype wire

/* File: sim/store_unpriv_dual_exclusive_tb_top.sv */
// Purpose: self-checking bench for the store decode and execute block
// Assumes: registers reached over the ahb-lite slave, memory answered by the partner model
// Notes: accesses are logged at each acked edge and compared after the operation
`timescale 1ns/1ps
`default_nettype none
module store_unpriv_dual_exclusive_tb_top;
	logic hclk, hresetn, hsel, hwrite, hready, hresp;
	logic [31:0] haddr, hwdata, hrdata, maddr, mwdata, s, d, b, oa, fa;
	logic [1:0] htrans, msize;
	logic [2:0] hsize, puw;
	logic mreq, munpriv, mexcl, maligned, mack, mpass, mprot, mbus, pf, bf, ue;
	logic [3:0] delay;
	logic pass_cfg, prot_cfg, bus_cfg;
	int fail_count, n_compared, n_pf, n_bf, n_ue, i;
	logic [31:0] q_addr[$], q_data[$];
	logic [4:0] q_attr[$];
	logic [31:0] unp[13];
	logic [2:0] modes[4] = '{3'b110, 3'b101, 3'b011, 3'b010};
	sud_core u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
		.mem_req(mreq), .mem_addr(maddr), .mem_wdata(mwdata), .mem_size(msize), .mem_unpriv(munpriv),
		.mem_excl(mexcl), .mem_aligned(maligned), .mem_ack(mack), .mem_excl_pass(mpass),
		.mem_prot_fault(mprot), .mem_bus_fault(mbus), .protection_fault(pf), .bus_error_fault(bf),
		.undef_exc(ue));
	sud_mem_model u_mem (.hclk(hclk), .hresetn(hresetn), .mem_req(mreq), .delay(delay), .pass_cfg(pass_cfg),
		.prot_cfg(prot_cfg), .bus_cfg(bus_cfg), .mem_ack(mack), .mem_excl_pass(mpass),
		.mem_prot_fault(mprot), .mem_bus_fault(mbus));
	// clock
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	// log acked accesses and exception pulses
	always @(posedge hclk) begin
		if (mreq && mack) begin
			q_addr.push_back(maddr);
			q_data.push_back(mwdata);
			q_attr.push_back({msize, munpriv, mexcl, maligned});
		end
		if (pf === 1'b1) n_pf++;
		if (bf === 1'b1) n_bf++;
		if (ue === 1'b1) n_ue++;
	end
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one single-word transfer: hold address until hready, then data until hready
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] t;
		xfer(1'b1, a, wd, t);
	endtask
	// load operands, start, poll status until idle with an outcome
	task automatic run(input logic [31:0] insn, input logic [31:0] base, input logic [31:0] src, input logic cond);
		q_addr.delete();
		q_data.delete();
		q_attr.delete();
		n_pf = 0;
		n_bf = 0;
		n_ue = 0;
		wr(sud_pkg::REG_INSN, insn);
		wr(sud_pkg::REG_BASE, base);
		wr(sud_pkg::REG_SRC, src);
		wr(sud_pkg::REG_SRC2, ~src);
		wr(sud_pkg::REG_CTRL, {30'h0, cond, 1'b1});
		s = 32'h1;
		for (int k = 0; k < 60 && (s[0] !== 1'b0 || s[9:1] === 9'h0); k++) xfer(1'b0, sud_pkg::REG_STAT, 0, s);
	endtask
	task automatic chk(input logic [31:0] stat, input int n);
		cmp("status flags", stat, s & 32'h3FC);
		cmp("access count", n, 32'(q_addr.size()));
		cmp("bus response", 32'h0, {31'h0, hresp});
	endtask
	task automatic acc(input int k, input logic [31:0] a, input logic [31:0] dat, input logic [4:0] attr);
		cmp("mem addr", a, (q_addr.size() > k) ? q_addr[k] : 32'hFFFFFFFF);
		cmp("mem data", dat, (q_data.size() > k) ? q_data[k] : 32'hFFFFFFFF);
		cmp("mem attr", {27'h0, attr}, (q_attr.size() > k) ? {27'h0, q_attr[k]} : 32'hFFFFFFFF);
	endtask
	function automatic logic [31:0] pr(input logic [2:0] m, input logic [3:0] rn, input logic [3:0] rt,
		input logic [3:0] rt2);
		return {7'h74, m[2], m[1], 1'b1, m[0], 1'b0, rn, rt, rt2, 8'hFF};
	endfunction
	// watchdog
	initial begin
		#400000;
		fail_count++;
		test_done();
	end
	initial begin
		unp = '{{12'hF80, 4'h1, 4'hD, 4'hE, 8'h10}, {12'hF80, 4'h1, 4'hF, 4'hE, 8'h10},
			pr(3'b111, 4'h2, 4'h2, 4'h3), pr(3'b111, 4'h3, 4'h2, 4'h3), pr(3'b110, 4'hF, 4'h2, 4'h3),
			pr(3'b110, 4'h1, 4'hD, 4'h3), pr(3'b110, 4'h1, 4'h2, 4'hF), {12'hE84, 4'h1, 4'h2, 4'hD, 8'h0},
			{12'hE84, 4'h1, 4'h2, 4'hF, 8'h0}, {12'hE84, 4'hF, 4'h2, 4'h4, 8'h0}, {12'hE84, 4'h1, 4'h2, 4'h1, 8'h0},
			{12'hE84, 4'h1, 4'h2, 4'h2, 8'h0}, {12'hE8C, 4'h1, 4'h2, 4'hF, 4'h4, 4'h1}};
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		delay = 4'h0;
		pass_cfg = 1'b1;
		prot_cfg = 1'b0;
		bus_cfg = 1'b0;
		hresetn = 1'b0;
		repeat (16) @(posedge hclk);
		hresetn <= 1'b1;
		// reset values and an unmapped place
		xfer(1'b0, sud_pkg::REG_STAT, 0, d);
		cmp("stat reset", 32'h0, d);
		xfer(1'b0, sud_pkg::REG_CTRL, 0, d);
		cmp("ctrl reset", 32'h2, d);
		wr(8'h20, 32'hFFFFFFFF);
		xfer(1'b0, 8'h20, 0, d);
		cmp("unmapped read", 32'h0, d);
		// unprivileged byte at base plus the largest offset
		run({12'hF80, 4'h1, 4'h2, 4'hE, 8'hFF}, 32'h1000, 32'hAABBCC5A, 1'b1);
		chk(32'h0, 1);
		acc(0, 32'h10FF, 32'h5A, 5'b00100);
		// base field all ones is undefined
		run({12'hF80, 4'hF, 4'h2, 4'hE, 8'h10}, 32'h1000, 32'h5, 1'b1);
		chk(32'h4, 0);
		cmp("undef pulses", 1, n_ue);
		// the four index and writeback modes of the pair store, slow memory
		delay = 4'h2;
		for (i = 0; i < 4; i++) begin
			puw = modes[i];
			b = 32'h4000;
			oa = puw[1] ? b + 32'd1020 : b - 32'd1020;
			fa = puw[2] ? oa : b;
			run(pr(puw, 4'h1, 4'h2, 4'h3), b, 32'h11223344, 1'b1);
			if (puw[2] == 1'b0 && puw[0] == 1'b0) begin
				chk(32'h100, 0);
			end else begin
				chk(puw[0] ? 32'h80 : 32'h0, 2);
				acc(0, fa, 32'h11223344, 5'b10001);
				acc(1, fa + 32'h4, 32'hEEDDCCBB, 5'b10001);
				xfer(1'b0, sud_pkg::REG_WBADDR, 0, d);
				if (puw[0]) cmp("new base", oa, d);
			end
		end
		delay = 4'h0;
		// unpredictable register choices never reach memory
		for (i = 0; i < 13; i++) begin
			run(unp[i], 32'h4000, 32'h7, 1'b1);
			chk(32'h8, 0);
		end
		// exclusive word, byte and half with the check passing and failing
		for (i = 0; i < 6; i++) begin
			pass_cfg = i[0];
			case (i / 2)
				0: run({12'hE84, 4'h1, 4'h2, 4'h4, 8'h03}, 32'h800, 32'hCAFE1234, 1'b1);
				1: run({12'hE8C, 4'h1, 4'h2, 4'hF, 4'h4, 4'h4}, 32'h801, 32'hCAFE1234, 1'b1);
				default: run({12'hE8C, 4'h1, 4'h2, 4'hF, 4'h5, 4'h4}, 32'h802, 32'hCAFE1234, 1'b1);
			endcase
			chk(i[0] ? 32'h0 : 32'h40, 1);
			xfer(1'b0, sud_pkg::REG_RESULT, 0, d);
			cmp("exclusive status", i[0] ? 32'h0 : 32'h1, d);
			if (i / 2 == 0) acc(0, 32'h80C, 32'hCAFE1234, 5'b10011);
			if (i / 2 == 1) acc(0, 32'h801, 32'h34, 5'b00011);
			if (i / 2 == 2) acc(0, 32'h802, 32'h1234, 5'b01011);
		end
		pass_cfg = 1'b1;
		// faults on the first word abort the pair and raise the matching exception
		prot_cfg = 1'b1;
		run(pr(3'b111, 4'h1, 4'h2, 4'h3), 32'h4000, 32'h9, 1'b1);
		chk(32'h10, 1);
		cmp("protection pulses", 1, n_pf);
		prot_cfg = 1'b0;
		bus_cfg = 1'b1;
		run(pr(3'b111, 4'h1, 4'h2, 4'h3), 32'h4000, 32'h9, 1'b1);
		chk(32'h20, 1);
		cmp("bus fault pulses", 1, n_bf);
		bus_cfg = 1'b0;
		// failed condition does nothing
		run({12'hE84, 4'h1, 4'h2, 4'h4, 8'h03}, 32'h800, 32'h1, 1'b0);
		chk(32'h0, 0);
		test_done();
	end
endmodule
`default_nettype wire
